/* File: conv_ctrl_pkg.sv */
package conv_ctrl_pkg;
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
  localparam logic [3:0] ADDR_ANALOG_EN_UPPER = 4'h1;
  localparam logic [3:0] ADDR_RESULT = 4'h2;
  localparam logic [3:0] ADDR_TRANSFER_ZERO = 4'h3;
  localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_BLOCK_SIZE = 4'h7;

  localparam int CHAN_MSB = 15;
  localparam int CHAN_LSB = 12;
  localparam int TRIG_MSB = 11;
  localparam int TRIG_LSB = 10;
  localparam int FORMAT_BIT = 9;
  localparam int INVERT_BIT = 8;
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 5;
  localparam int CLKSRC_MSB = 4;
  localparam int CLKSRC_LSB = 3;
  localparam int SEQ_MSB = 2;
  localparam int SEQ_LSB = 1;
  localparam int BUSY_BIT = 0;
  localparam int AE_MSB = 7;
  localparam int AE_LSB = 4;
  localparam int TWO_BLOCK_BIT = 3;
  localparam int CONT_BIT = 2;
  localparam int BLOCK_ONE_BIT = 1;
  localparam int FETCH_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int START_BIT = 0;
  localparam int IRQ_RESULT_BIT = 0;
  localparam int IRQ_BLOCK_BIT = 1;

  localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
  localparam logic [7:0] AE_RESET = 8'h00;
  localparam logic [7:0] TRANSFER_RESET = 8'h00;
  localparam logic [7:0] BLOCK_SIZE_RESET = 8'h00;
  localparam logic [9:0] SAMPLE_RESET = 10'h000;

  localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_SEQUENCE = 2'h1;
  localparam logic [1:0] SEQ_REPEAT_SINGLE = 2'h2;
  localparam logic [1:0] SEQ_REPEAT_SEQUENCE = 2'h3;

  // Conversion length in divided conversion-clock ticks
  localparam logic [3:0] CONV_TICKS = 4'hd;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    CONVERT = 3'b010,
    FINISH = 3'b100
  } conv_state_type;
endpackage

/* File: conv_ctrl.sv */
// How it works
// [RQ1] Four-bit channel field picks single channel or highest sequence channel.
// [RQ2] Two-bit trigger source: software start bit or one of three timer outputs.
// [RQ3] Format clear: result right-justified binary, bits 15-10 zero.
// [RQ4] Format set: result left-justified two's complement, bits 5-0 zero.
// [RQ5] Conversion clock divided by divider field plus one.
// [RQ6] Two-bit field selects one of four conversion clock sources.
// [RQ7] Four sequence modes: single, sequence, repeat single, repeat sequence.
// [RQ8] Read-only busy bit high while any sequence, sample or conversion active.
// [RQ9] Upper analog-enable bits 7-4 enable pins A12-A15; low nibble reserved.
// [RQ10] Two-block bit chooses one-block or two-block transfer mode.
// [RQ11] Continuous bit clear stops after the block(s); set transfers continuously.
// [RQ12] Block-one bit reports last filled block, valid after first flag.
// [RQ13] Flag set per result, or per completed block when transferring.
// [RQ14] Configuration fields ignore writes while conversion enable is set.
// [RQ15] Transfer register upper nibble reads zero; fetch bit cleared at reset.
`timescale 1ns/1ps
module conv_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire conv_ctrl_pkg::bus_req_type busReq,
  output logic [15:0] readData,
  input wire logic [3:0] clockSources,
  input wire logic [2:0] timerOutputs,
  input wire logic [9:0] sampleCode,
  output logic [3:0] channelSelect,
  output logic [3:0] analogPinEnable,
  output logic irq
);
  import conv_ctrl_pkg::*;

  logic [15:0] controlOne;
  logic [7:0] analogEnable;
  logic [15:0] result;
  logic twoBlock;
  logic continuous;
  logic blockOne;
  logic fetchControl;
  logic convEnable;
  logic [7:0] blockSize;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  conv_state_type state;
  logic [3:0] tickCount;
  logic [3:0] currentChannel;
  logic [7:0] transferCount;
  logic secondBlock;
  logic transferDone;
  logic [2:0] divCount;
  logic divTick;
  logic [2:0] syncClk0, syncClk1, syncClk2;
  logic [2:0] syncTrig0, syncTrig1, syncTrig2;
  logic srcClkLevel;
  logic srcClkPrev;
  logic trigLevel;
  logic trigPrev;
  logic [9:0] sampleSync1, sampleSync2, sampleSync3;
  logic [9:0] sampleHeld;
  logic softStart;

  logic wrCtl1, wrAe, wrDtc, wrCtl0, wrIrq, wrMask, wrSize;
  logic resultEvent;
  logic blockEvent;
  logic [1:0] irqEvents;
  logic trigEdge;
  logic srcEdge;
  logic [1:0] trigSel;
  logic [1:0] seqMode;
  logic lastChannel;
  logic repeatMode;
  logic transferActive;
  logic [15:0] formatted;
  logic [15:0] next_read;

  assign wrCtl1 = busReq.wr && busReq.addr == ADDR_CONTROL_ONE;
  assign wrAe = busReq.wr && busReq.addr == ADDR_ANALOG_EN_UPPER;
  assign wrDtc = busReq.wr && busReq.addr == ADDR_TRANSFER_ZERO;
  assign wrCtl0 = busReq.wr && busReq.addr == ADDR_CONTROL_ZERO;
  assign wrIrq = busReq.wr && busReq.addr == ADDR_IRQ_STATUS;
  assign wrMask = busReq.wr && busReq.addr == ADDR_IRQ_MASK;
  assign wrSize = busReq.wr && busReq.addr == ADDR_BLOCK_SIZE;
  assign trigSel = controlOne[TRIG_MSB:TRIG_LSB];
  assign seqMode = controlOne[SEQ_MSB:SEQ_LSB];

  // Pin-level inputs pass three flops; second and third must agree
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          syncClk0[i] <= 1'b0;
          syncClk1[i] <= 1'b0;
          syncClk2[i] <= 1'b0;
          syncTrig0[i] <= 1'b0;
          syncTrig1[i] <= 1'b0;
          syncTrig2[i] <= 1'b0;
        end else begin
          syncClk0[i] <= clockSources[i + 1];
          syncClk1[i] <= syncClk0[i];
          syncClk2[i] <= syncClk1[i];
          syncTrig0[i] <= timerOutputs[i];
          syncTrig1[i] <= syncTrig0[i];
          syncTrig2[i] <= syncTrig1[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleSync1 <= SAMPLE_RESET;
      sampleSync2 <= SAMPLE_RESET;
      sampleSync3 <= SAMPLE_RESET;
      sampleHeld <= SAMPLE_RESET;
    end else begin
      sampleSync1 <= sampleCode;
      sampleSync2 <= sampleSync1;
      sampleSync3 <= sampleSync2;
      // A code is captured only when two successive samples agree, so a mix seen in one sample alone is dropped
      if (sampleSync2 == sampleSync3) begin
        sampleHeld <= sampleSync3;
      end
    end
  end

  // Source clock select; the internal oscillator is a flop toggled every clk, giving clk/2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcClkLevel <= 1'b0;
      srcClkPrev <= 1'b0;
      trigLevel <= 1'b0;
      trigPrev <= 1'b0;
    end else begin
      // [RQ6] clock source select
      if (controlOne[CLKSRC_MSB:CLKSRC_LSB] != 2'h0) begin
        if (syncClk1[controlOne[CLKSRC_MSB:CLKSRC_LSB] - 2'h1] ==
            syncClk2[controlOne[CLKSRC_MSB:CLKSRC_LSB] - 2'h1]) begin
          srcClkLevel <= syncClk2[controlOne[CLKSRC_MSB:CLKSRC_LSB] - 2'h1];
        end
      end else begin
        srcClkLevel <= ~srcClkLevel;
      end
      srcClkPrev <= srcClkLevel;
      // [RQ2] timer trigger select
      if (trigSel != TRIG_SOFTWARE && syncTrig1[trigSel - 2'h1] == syncTrig2[trigSel - 2'h1]) begin
        trigLevel <= syncTrig2[trigSel - 2'h1] ^ controlOne[INVERT_BIT];
      end
      trigPrev <= trigLevel;
    end
  end

  assign srcEdge = srcClkLevel && !srcClkPrev;
  assign trigEdge = trigSel == TRIG_SOFTWARE ? softStart : (trigLevel && !trigPrev);

  // [RQ5] divide by field plus one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= 3'h0;
      divTick <= 1'b0;
    end else begin
      divTick <= 1'b0;
      if (srcEdge) begin
        if (divCount >= controlOne[DIV_MSB:DIV_LSB]) begin
          divCount <= 3'h0;
          divTick <= 1'b1;
        end else begin
          divCount <= divCount + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convEnable <= 1'b0;
      softStart <= 1'b0;
    end else begin
      softStart <= wrCtl0 && busReq.wdata[START_BIT] && busReq.wdata[ENABLE_BIT];
      if (wrCtl0) begin
        convEnable <= busReq.wdata[ENABLE_BIT];
      end
    end
  end

  assign lastChannel = currentChannel == 4'h0;
  assign repeatMode = seqMode == SEQ_REPEAT_SINGLE || seqMode == SEQ_REPEAT_SEQUENCE;

  // [RQ7] sequence mode engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      tickCount <= 4'h0;
      currentChannel <= 4'h0;
    end else begin
      case (state)
        IDLE: begin
          if (trigEdge && convEnable) begin
            state <= CONVERT;
            tickCount <= 4'h0;
            // [RQ1] channel field start
            currentChannel <= controlOne[CHAN_MSB:CHAN_LSB];
          end
        end
        CONVERT: begin
          if (divTick) begin
            if (tickCount == CONV_TICKS - 4'h1) begin
              state <= FINISH;
            end else begin
              tickCount <= tickCount + 4'h1;
            end
          end
        end
        FINISH: begin
          tickCount <= 4'h0;
          if (seqMode == SEQ_SEQUENCE || seqMode == SEQ_REPEAT_SEQUENCE) begin
            if (!lastChannel) begin
              currentChannel <= currentChannel - 4'h1;
              state <= CONVERT;
            end else if (repeatMode && convEnable && !transferDone) begin
              currentChannel <= controlOne[CHAN_MSB:CHAN_LSB];
              state <= CONVERT;
            end else begin
              state <= IDLE;
            end
          end else if (repeatMode && convEnable && !transferDone) begin
            state <= CONVERT;
          end else begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  assign resultEvent = state == FINISH;
  assign transferActive = blockSize != 8'h00;

  // [RQ3] right-justified binary; [RQ4] left-justified two's complement
  assign formatted = controlOne[FORMAT_BIT] ?
    {~sampleHeld[9], sampleHeld[8:0], 6'h00} : {6'h00, sampleHeld};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 16'h0000;
    end else if (resultEvent) begin
      result <= formatted;
    end
  end

  // Transfer controller block counting
  assign blockEvent = resultEvent && transferActive && !transferDone &&
                      transferCount == blockSize - 8'h01;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transferCount <= 8'h00;
      secondBlock <= 1'b0;
      blockOne <= 1'b0;
      transferDone <= 1'b0;
    end else begin
      if (wrDtc || wrSize) begin
        transferCount <= 8'h00;
        secondBlock <= 1'b0;
        transferDone <= 1'b0;
      end else if (resultEvent && transferActive && !transferDone) begin
        if (blockEvent) begin
          transferCount <= 8'h00;
          // [RQ12] block just filled
          blockOne <= !secondBlock;
          // [RQ10] one or two blocks
          if (twoBlock) begin
            secondBlock <= !secondBlock;
          end
          // [RQ11] stop unless continuous
          if (!continuous && (!twoBlock || secondBlock)) begin
            transferDone <= 1'b1;
          end
        end else begin
          transferCount <= transferCount + 8'h01;
        end
      end
    end
  end

  // [RQ14] writes ignored while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      controlOne <= CONTROL_ONE_RESET;
    end else if (wrCtl1 && !convEnable) begin
      controlOne <= {busReq.wdata[15:1], 1'b0};
    end
  end

  // [RQ15] reserved nibble dropped; fetch reset clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      twoBlock <= TRANSFER_RESET[TWO_BLOCK_BIT];
      continuous <= TRANSFER_RESET[CONT_BIT];
      fetchControl <= TRANSFER_RESET[FETCH_BIT];
      blockSize <= BLOCK_SIZE_RESET;
      analogEnable <= AE_RESET;
    end else begin
      if (wrDtc) begin
        twoBlock <= busReq.wdata[TWO_BLOCK_BIT];
        continuous <= busReq.wdata[CONT_BIT];
        fetchControl <= busReq.wdata[FETCH_BIT];
      end
      if (wrSize) begin
        blockSize <= busReq.wdata[7:0];
      end
      if (wrAe) begin
        analogEnable <= busReq.wdata[7:0];
      end
    end
  end

  // [RQ13] flag per result or per block
  assign irqEvents[IRQ_RESULT_BIT] = resultEvent && !transferActive;
  assign irqEvents[IRQ_BLOCK_BIT] = blockEvent;
  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= 2'h0;
      irqMask <= 2'h0;
      irq <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~(wrIrq ? busReq.wdata[1:0] : 2'h0)) | irqEvents;
      if (wrMask) begin
        irqMask <= busReq.wdata[1:0];
      end
      irq <= |(irqStatus & irqMask);
    end
  end

  always_comb begin
    next_read = 16'h0000;
    case (busReq.addr)
      ADDR_CONTROL_ONE: begin
        next_read = controlOne;
        // [RQ8] busy while not idle
        next_read[BUSY_BIT] = state != IDLE;
      end
      ADDR_ANALOG_EN_UPPER: next_read = {8'h00, analogEnable[AE_MSB:AE_LSB], 4'h0};
      ADDR_RESULT: next_read = result;
      ADDR_TRANSFER_ZERO: next_read = {12'h000, twoBlock, continuous, blockOne, fetchControl};
      ADDR_CONTROL_ZERO: next_read = {14'h0000, convEnable, 1'b0};
      ADDR_IRQ_STATUS: next_read = {14'h0000, irqStatus};
      ADDR_IRQ_MASK: next_read = {14'h0000, irqMask};
      ADDR_BLOCK_SIZE: next_read = {8'h00, blockSize};
      default: next_read = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 16'h0000;
      channelSelect <= 4'h0;
      analogPinEnable <= 4'h0;
    end else begin
      readData <= busReq.rd ? next_read : 16'h0000;
      channelSelect <= currentChannel;
      // [RQ9] pins A12-A15
      analogPinEnable <= analogEnable[AE_MSB:AE_LSB];
    end
  end
endmodule

/* File: conv_ctrl_monitor.sv */
`timescale 1ns/1ps
module conv_ctrl_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire conv_ctrl_pkg::bus_req_type busReq,
  input wire logic [15:0] readData,
  input wire logic [3:0] analogPinEnable,
  input wire logic irq
);
  import conv_ctrl_pkg::*;
  logic enabled;
  logic [15:0] ctlShadow;
  logic [3:0] aeShadow;
  logic [3:0] dtcShadow;

  // Software view of the registers; control one is frozen while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enabled <= 1'b0;
      ctlShadow <= CONTROL_ONE_RESET;
      aeShadow <= 4'h0;
      dtcShadow <= 4'h0;
    end else if (busReq.wr) begin
      case (busReq.addr)
        ADDR_CONTROL_ZERO: enabled <= busReq.wdata[ENABLE_BIT];
        ADDR_CONTROL_ONE: ctlShadow <= enabled ? ctlShadow : busReq.wdata;
        ADDR_ANALOG_EN_UPPER: aeShadow <= busReq.wdata[AE_MSB:AE_LSB];
        ADDR_TRANSFER_ZERO: dtcShadow <= {busReq.wdata[3:2], 1'b0, busReq.wdata[0]};
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [3:0] a);
    busReq.rd && busReq.addr == a;
  endsequence
  sequence s_soft_start;
    busReq.wr && busReq.addr == ADDR_CONTROL_ZERO && busReq.wdata[1:0] == 2'h3
      && ctlShadow[TRIG_MSB:TRIG_LSB] == TRIG_SOFTWARE;
  endsequence

  property p_read_idle;
    !busReq.rd |=> readData == 16'h0000;
  endproperty
  property p_ctl_lock;
    s_rd(ADDR_CONTROL_ONE) |=> readData[15:1] == ctlShadow[15:1];
  endproperty
  property p_ae_read;
    s_rd(ADDR_ANALOG_EN_UPPER) |=> readData == {8'h00, aeShadow, 4'h0};
  endproperty
  property p_ae_pins;
    busReq.wr && busReq.addr == ADDR_ANALOG_EN_UPPER |->
      ##2 analogPinEnable == $past(busReq.wdata[AE_MSB:AE_LSB], 2);
  endproperty
  property p_result;
    s_rd(ADDR_RESULT) |=> readData[15:10] == 6'h00 || readData[5:0] == 6'h00;
  endproperty
  property p_dtc_read;
    s_rd(ADDR_TRANSFER_ZERO) |=> (readData & 16'hfffd) == {12'h000, dtcShadow};
  endproperty
  // Tasks leave one idle cycle between accesses
  property p_busy_on;
    s_soft_start ##2 s_rd(ADDR_CONTROL_ONE) |=> readData[BUSY_BIT];
  endproperty
  property p_irq_off;
    busReq.wr && busReq.addr == ADDR_IRQ_MASK && busReq.wdata[1:0] == 2'h0 |-> ##2 !irq;
  endproperty

  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside a reply");
  a_ctl_lock: assert property (p_ctl_lock)
    else $error("control one read back wrong");
  a_ae_read: assert property (p_ae_read)
    else $error("analog enable read back wrong");
  a_ae_pins: assert property (p_ae_pins)
    else $error("analog pin enables wrong");
  a_result: assert property (p_result)
    else $error("result padding bits not zero");
  a_dtc_read: assert property (p_dtc_read)
    else $error("transfer control read back wrong");
  a_busy_on: assert property (p_busy_on)
    else $error("busy low after software start");
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with all sources masked");
endmodule

bind conv_ctrl conv_ctrl_monitor mon_u (
  .clk(clk),
  .rst_n(rst_n),
  .busReq(busReq),
  .readData(readData),
  .analogPinEnable(analogPinEnable),
  .irq(irq)
);

/* File: tb_conv_ctrl.sv */
`timescale 1ns/1ps
module tb_conv_ctrl;
  import conv_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_type busReq = '0;
  logic [15:0] readData;
  logic [3:0] clockSources = 4'h0;
  logic [2:0] timerOutputs = 3'h0;
  logic [9:0] sampleCode = 10'h2b5;
  logic [3:0] channelSelect;
  logic [3:0] analogPinEnable;
  logic irq;
  logic [15:0] v;
  int failCount = 0;
  int nTests = 0;

  conv_ctrl dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .busReq(busReq),
    .readData(readData),
    .clockSources(clockSources),
    .timerOutputs(timerOutputs),
    .sampleCode(sampleCode),
    .channelSelect(channelSelect),
    .analogPinEnable(analogPinEnable),
    .irq(irq)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // All four sources run, at clk/2 to clk/16
  always @(posedge clk) begin
    clockSources <= clockSources + 4'h1;
  end

  task automatic endOfTest();
    $display("checks %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq.addr <= a;
    busReq.wdata <= d;
    busReq.wr <= 1'b1;
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rdChk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    chk(what, exp, readData);
  endtask

  task automatic waitIrq();
    for (int i = 0; i < 1000 && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("irq", 16'h0001, {15'h0, irq});
  endtask

  initial begin
    #(25 * 20000);
    failCount++;
    endOfTest();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdChk("control one", ADDR_CONTROL_ONE, CONTROL_ONE_RESET);
    rdChk("transfer control", ADDR_TRANSFER_ZERO, 16'h0000);
    rdChk("unmapped", 4'hf, 16'h0000);
    wrReg(ADDR_ANALOG_EN_UPPER, 16'hffff);
    rdChk("analog enable", ADDR_ANALOG_EN_UPPER, 16'h00f0);
    wrReg(ADDR_ANALOG_EN_UPPER, 16'h0050);
    // Pin enables follow the register one cycle later
    @(posedge clk);
    #1;
    chk("pin enable", 16'h0005, {12'h0, analogPinEnable});
    wrReg(ADDR_TRANSFER_ZERO, 16'hffff);
    rdChk("transfer control", ADDR_TRANSFER_ZERO, 16'h000d);
    wrReg(ADDR_TRANSFER_ZERO, 16'h0000);
    // Every code of each field passes through the loop
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], i[1:0], i[0], i[1], i[2:0], i[1:0], i[1:0], 1'b0};
      wrReg(ADDR_CONTROL_ONE, v);
      rdChk("control one", ADDR_CONTROL_ONE, v);
    end
    wrReg(ADDR_IRQ_MASK, 16'h0003);
    wrReg(ADDR_CONTROL_ONE, 16'ha020);
    wrReg(ADDR_CONTROL_ZERO, 16'h0003);
    rdChk("busy", ADDR_CONTROL_ONE, 16'ha021);
    chk("channel", 16'h000a, {12'h0, channelSelect});
    wrReg(ADDR_CONTROL_ONE, 16'h1234);
    waitIrq();
    rdChk("result", ADDR_RESULT, {6'h00, sampleCode});
    rdChk("locked control", ADDR_CONTROL_ONE, 16'ha020);
    rdChk("status", ADDR_IRQ_STATUS, 16'h0001);
    wrReg(ADDR_IRQ_STATUS, 16'h0001);
    rdChk("cleared status", ADDR_IRQ_STATUS, 16'h0000);
    chk("irq clear", 16'h0000, {15'h0, irq});
    // Timer trigger, two's complement, sub-main clock
    wrReg(ADDR_CONTROL_ZERO, 16'h0000);
    wrReg(ADDR_CONTROL_ONE, 16'ha618);
    sampleCode <= 10'h1c3;
    wrReg(ADDR_CONTROL_ZERO, 16'h0002);
    timerOutputs <= 3'h1;
    waitIrq();
    timerOutputs <= 3'h0;
    rdChk("result", ADDR_RESULT, {~sampleCode[9], sampleCode[8:0], 6'h00});
    wrReg(ADDR_IRQ_MASK, 16'h0000);
    rdChk("status", ADDR_IRQ_STATUS, 16'h0001);
    chk("masked irq", 16'h0000, {15'h0, irq});
    // Two-block transfer of two-channel sequences, then a stopped third run
    wrReg(ADDR_CONTROL_ZERO, 16'h0000);
    wrReg(ADDR_IRQ_STATUS, 16'h0003);
    wrReg(ADDR_CONTROL_ONE, 16'h1002);
    wrReg(ADDR_BLOCK_SIZE, 16'h0002);
    wrReg(ADDR_TRANSFER_ZERO, 16'h0008);
    wrReg(ADDR_IRQ_MASK, 16'h0002);
    for (int b = 0; b < 2; b++) begin
      wrReg(ADDR_CONTROL_ZERO, 16'h0003);
      waitIrq();
      rdChk("block flag", ADDR_TRANSFER_ZERO, b == 0 ? 16'h000a : 16'h0008);
      rdChk("block status", ADDR_IRQ_STATUS, 16'h0002);
      wrReg(ADDR_IRQ_STATUS, 16'h0002);
    end
    wrReg(ADDR_CONTROL_ZERO, 16'h0003);
    repeat (100) @(posedge clk);
    rdChk("stopped status", ADDR_IRQ_STATUS, 16'h0000);
    rdChk("binary result", ADDR_RESULT, 16'h01c3);
    chk("last channel", 16'h0000, {12'h0, channelSelect});
    endOfTest();
  end
endmodule
